// *** strap_default_config_loader.sv ***
// strap loader: samples power-on straps, holds unit config, drives shared pins
// Functional notes
// - five straps select channel and watchdog defaults
// - straps pulled up, sampled on every reset
// - channel a straps load enable, base, irq
// - channel b straps load enable, base, irq
// - both straps high give x_f8 base
// - watchdog strap loads enable, base 0x442
// - strapped registers stay software writable
// - serial out idles high, also in reset
// - infrared out idles low, also in reset
// - modem inputs active low or general purpose
// - channel a modem outputs active low or general purpose, channel b terminal ready active low only
// - watchdog output open drain, active low
`timescale 1ns/1ps
`default_nettype none
`include "strap_loader_consts.svh"

module strap_default_config_loader (
  input wire logic sys_clk_i, // system clock
  input wire logic resetn_i, // bus reset, active low, async
  input wire logic cfg_wr_i, // config write strobe
  input wire logic [7:0] cfg_ldn_i, // logical device number
  input wire logic [7:0] cfg_index_i, // register index
  input wire logic [7:0] cfg_wdata_i, // write data
  output logic [7:0] cfg_rdata_o, // read data, one cycle after index
  output logic cfg_ready_o, // straps captured, accesses allowed
  input wire logic a_tx_bit_i, // channel a datapath serial bit
  input wire logic a_ir_tx_bit_i, // channel a datapath infrared bit
  input wire logic a_send_request_i, // channel a request to send, active high
  input wire logic a_terminal_ready_i, // channel a terminal ready, active high
  input wire logic b_tx_bit_i, // channel b datapath serial bit
  input wire logic b_terminal_ready_i, // channel b terminal ready, active high
  input wire logic watchdog_fire_i, // watchdog expired, active high
  output logic a_rx_bit_o, // channel a receive bit, synchronised
  output logic a_ir_rx_bit_o, // channel a infrared receive bit
  output logic a_set_ready_o, // channel a set ready, active high
  output logic a_ring_o, // channel a ring, active high
  output logic a_carrier_o, // channel a carrier, active high
  input wire logic chan_a_serial_out_i, // serial out ball level, strap
  output logic chan_a_serial_out_o, // serial out drive level
  output logic chan_a_serial_out_oe_o, // serial out drive enable
  input wire logic chan_a_terminal_ready_n_i, // terminal ready ball level, strap
  output logic chan_a_terminal_ready_n_o, // terminal ready drive level
  output logic chan_a_terminal_ready_n_oe_o, // terminal ready drive enable
  output logic chan_a_send_request_n_o, // request to send pin
  output logic chan_a_infrared_out_o, // infrared out pin
  input wire logic chan_a_serial_in_i, // serial in pin
  input wire logic chan_a_infrared_in_i, // infrared in pin
  input wire logic chan_a_set_ready_n_i, // set ready pin
  input wire logic chan_a_ring_n_i, // ring pin
  input wire logic chan_a_carrier_n_i, // carrier pin
  input wire logic chan_b_serial_out_i, // channel b serial out ball, strap
  output logic chan_b_serial_out_o, // channel b serial out drive level
  output logic chan_b_serial_out_oe_o, // channel b serial out drive enable
  input wire logic chan_b_terminal_ready_n_i, // channel b terminal ready ball, strap
  output logic chan_b_terminal_ready_n_o, // channel b terminal ready drive level
  output logic chan_b_terminal_ready_n_oe_o, // channel b terminal ready drive enable
  input wire logic watchdog_expire_n_i, // watchdog ball level, strap
  output logic watchdog_expire_n_o, // watchdog drive level, always low
  output logic watchdog_expire_n_oe_o // watchdog drive enable, high pulls low
);

  // two-flop synchronisers for every pin input
  logic [`SY_WIDTH-1:0] sync_meta; // first stage, read only by sync_out
  logic [`SY_WIDTH-1:0] sync_out; // second stage
  wire [`SY_WIDTH-1:0] pin_in = {chan_a_carrier_n_i, chan_a_ring_n_i, chan_a_set_ready_n_i,
    chan_a_infrared_in_i, chan_a_serial_in_i, watchdog_expire_n_i, chan_b_serial_out_i,
    chan_b_terminal_ready_n_i, chan_a_serial_out_i, chan_a_terminal_ready_n_i};

  // reset levels match pull-ups and idle lines
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_meta <= `SY_RESET;
      sync_out <= `SY_RESET;
    end else begin
      sync_meta <= pin_in;
      sync_out <= sync_meta;
    end
  end

  // capture sequence: two edges for the synchroniser, then load
  strap_loader_pkg::capture_state_t cap_state; // capture progress
  strap_loader_pkg::capture_state_t next_cap_state; // next capture state
  always_comb begin
    unique case (cap_state)
      strap_loader_pkg::CAP_SYNC1: next_cap_state = strap_loader_pkg::CAP_SYNC2;
      strap_loader_pkg::CAP_SYNC2: next_cap_state = strap_loader_pkg::CAP_LOAD;
      strap_loader_pkg::CAP_LOAD: next_cap_state = strap_loader_pkg::CAP_DONE;
      strap_loader_pkg::CAP_DONE: next_cap_state = strap_loader_pkg::CAP_DONE;
    endcase
  end

  // every reset restarts sampling
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_state <= strap_loader_pkg::CAP_SYNC1;
    end else begin
      cap_state <= next_cap_state;
    end
  end

  wire load_now = (cap_state == strap_loader_pkg::CAP_LOAD); // defaults load strobe
  wire done = (cap_state == strap_loader_pkg::CAP_DONE); // straps captured

  // defaults decoded from the synchronised strap levels
  logic [2:0][7:0] def_enable; // default enable
  logic [2:0][7:0] def_base_high; // default base high
  logic [2:0][7:0] def_base_low; // default base low
  logic [2:0][7:0] def_irq; // default irq select
  strap_default_decoder decoder (
    .a_low_i(sync_out[`SY_STRAP_A_LOW]),
    .a_high_i(sync_out[`SY_STRAP_A_HIGH]),
    .b_low_i(sync_out[`SY_STRAP_B_LOW]),
    .b_high_i(sync_out[`SY_STRAP_B_HIGH]),
    .wdt_i(sync_out[`SY_STRAP_WDT]),
    .enable_o(def_enable),
    .base_high_o(def_base_high),
    .base_low_o(def_base_low),
    .irq_o(def_irq)
  );

  // maps a logical device number onto a unit index, valid flag in bit 2
  function automatic logic [2:0] unit_of(input logic [7:0] ldn);
    unit_of = 3'h0;
    if (ldn == `LDN_CHAN_A) begin
      unit_of = {1'b1, strap_loader_pkg::UNIT_A};
    end else if (ldn == `LDN_CHAN_B) begin
      unit_of = {1'b1, strap_loader_pkg::UNIT_B};
    end else if (ldn == `LDN_WATCHDOG) begin
      unit_of = {1'b1, strap_loader_pkg::UNIT_WDT};
    end
  endfunction

  // access decode
  wire [2:0] sel = unit_of(cfg_ldn_i); // selected unit and valid flag
  wire sel_ok = sel[2]; // ldn maps to a unit
  wire [1:0] sel_unit = sel[1:0]; // unit index
  wire wr_ok = cfg_wr_i & done & sel_ok; // writes ignored before capture
  wire sel_a = sel_ok & (sel_unit == strap_loader_pkg::UNIT_A); // channel a selected

  // per-unit configuration registers
  logic [2:0][7:0] unit_enable; // enable
  logic [2:0][7:0] io_base_high; // base address high
  logic [2:0][7:0] io_base_low; // base address low
  logic [2:0][7:0] interrupt_line_select; // irq select
  logic [7:0] pin_mode; // channel a modem pin mode, 1 = general purpose
  logic [7:0] gpio_out; // general purpose output levels

  genvar u;
  generate
    for (u = 0; u < 3; u++) begin : g_unit
      wire hit = wr_ok & (sel_unit == 2'(u)); // this unit written
      // strap load in CAP_LOAD, third edge after release, software writes afterwards replace it
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          unit_enable[u] <= 8'h00;
          io_base_high[u] <= 8'h00;
          io_base_low[u] <= 8'h00;
          interrupt_line_select[u] <= 8'h00;
        end else if (load_now) begin
          unit_enable[u] <= def_enable[u];
          io_base_high[u] <= def_base_high[u];
          io_base_low[u] <= def_base_low[u];
          interrupt_line_select[u] <= def_irq[u];
        end else if (hit) begin
          if (cfg_index_i == `OFS_UNIT_ENABLE) begin
            unit_enable[u] <= cfg_wdata_i;
          end
          if (cfg_index_i == `OFS_IO_BASE_HIGH) begin
            io_base_high[u] <= cfg_wdata_i;
          end
          if (cfg_index_i == `OFS_IO_BASE_LOW) begin
            io_base_low[u] <= cfg_wdata_i;
          end
          if (cfg_index_i == `OFS_IRQ_SELECT) begin
            interrupt_line_select[u] <= cfg_wdata_i;
          end
        end
      end
    end
  endgenerate

  // channel a pin mode and gpio output registers
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_mode <= 8'h00;
      gpio_out <= 8'h00;
    end else if (wr_ok & sel_a) begin
      if (cfg_index_i == `OFS_PIN_MODE) begin
        pin_mode <= cfg_wdata_i;
      end
      if (cfg_index_i == `OFS_GPIO_OUT) begin
        gpio_out <= cfg_wdata_i;
      end
    end
  end

  // gpio input view of modem pins, raw pin levels
  wire [7:0] gpio_in = {5'h00, sync_out[`SY_CARRIER_N], sync_out[`SY_RING_N], sync_out[`SY_SET_READY_N]};

  // read mux; unmapped indexes and devices read zero
  wire [7:0] rd_mux =
    !sel_ok ? 8'h00 :
    (cfg_index_i == `OFS_UNIT_ENABLE) ? unit_enable[sel_unit] :
    (cfg_index_i == `OFS_IO_BASE_HIGH) ? io_base_high[sel_unit] :
    (cfg_index_i == `OFS_IO_BASE_LOW) ? io_base_low[sel_unit] :
    (cfg_index_i == `OFS_IRQ_SELECT) ? interrupt_line_select[sel_unit] :
    (sel_a & (cfg_index_i == `OFS_PIN_MODE)) ? pin_mode :
    (sel_a & (cfg_index_i == `OFS_GPIO_OUT)) ? gpio_out :
    (sel_a & (cfg_index_i == `OFS_GPIO_IN)) ? gpio_in : 8'h00;

  // pin drive terms
  wire a_on = unit_enable[strap_loader_pkg::UNIT_A][0]; // channel a enabled
  wire b_on = unit_enable[strap_loader_pkg::UNIT_B][0]; // channel b enabled
  wire w_on = unit_enable[strap_loader_pkg::UNIT_WDT][0]; // watchdog enabled
  wire a_tx_level = a_on ? a_tx_bit_i : 1'b1; // idle high when not sending
  wire a_ir_level = a_on & a_ir_tx_bit_i; // idle low
  wire a_rts_n = pin_mode[`PM_SEND_REQUEST] ? gpio_out[`PM_SEND_REQUEST] : ~a_send_request_i;
  wire a_dtr_n = pin_mode[`PM_TERMINAL_READY] ? gpio_out[`PM_TERMINAL_READY] : ~a_terminal_ready_i;
  wire b_tx_level = b_on ? b_tx_bit_i : 1'b1; // idle high when not sending

  // registered outputs; strap balls are released until capture ends
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_rdata_o <= 8'h00;
      cfg_ready_o <= 1'b0;
      chan_a_serial_out_o <= 1'b1;
      chan_a_serial_out_oe_o <= 1'b0;
      chan_a_infrared_out_o <= 1'b0;
      chan_a_terminal_ready_n_o <= 1'b1;
      chan_a_terminal_ready_n_oe_o <= 1'b0;
      chan_a_send_request_n_o <= 1'b1;
      chan_b_serial_out_o <= 1'b1;
      chan_b_serial_out_oe_o <= 1'b0;
      chan_b_terminal_ready_n_o <= 1'b1;
      chan_b_terminal_ready_n_oe_o <= 1'b0;
      watchdog_expire_n_o <= 1'b0;
      watchdog_expire_n_oe_o <= 1'b0;
      a_rx_bit_o <= 1'b1;
      a_ir_rx_bit_o <= 1'b0;
      a_set_ready_o <= 1'b0;
      a_ring_o <= 1'b0;
      a_carrier_o <= 1'b0;
    end else begin
      cfg_rdata_o <= rd_mux;
      cfg_ready_o <= done | load_now;
      chan_a_serial_out_o <= done ? a_tx_level : 1'b1;
      chan_a_serial_out_oe_o <= done;
      chan_a_infrared_out_o <= done & a_ir_level;
      chan_a_terminal_ready_n_o <= done ? a_dtr_n : 1'b1;
      chan_a_terminal_ready_n_oe_o <= done;
      chan_a_send_request_n_o <= done ? a_rts_n : 1'b1;
      chan_b_serial_out_o <= done ? b_tx_level : 1'b1;
      chan_b_serial_out_oe_o <= done;
      chan_b_terminal_ready_n_o <= done ? ~b_terminal_ready_i : 1'b1;
      chan_b_terminal_ready_n_oe_o <= done;
      watchdog_expire_n_o <= 1'b0;
      watchdog_expire_n_oe_o <= done & w_on & watchdog_fire_i;
      a_rx_bit_o <= sync_out[`SY_RX];
      a_ir_rx_bit_o <= sync_out[`SY_IR_RX];
      a_set_ready_o <= ~pin_mode[`PM_SET_READY] & ~sync_out[`SY_SET_READY_N];
      a_ring_o <= ~pin_mode[`PM_RING] & ~sync_out[`SY_RING_N];
      a_carrier_o <= ~pin_mode[`PM_CARRIER] & ~sync_out[`SY_CARRIER_N];
    end
  end

endmodule
`default_nettype wire

// *** strap_loader_consts.svh ***
// offsets, field positions, strap defaults and synchroniser layout of the strap loader
`ifndef STRAP_LOADER_CONSTS_SVH
`define STRAP_LOADER_CONSTS_SVH

// configuration register indexes inside a logical device
`define OFS_UNIT_ENABLE 8'h30
`define OFS_IO_BASE_HIGH 8'h60
`define OFS_IO_BASE_LOW 8'h61
`define OFS_IRQ_SELECT 8'h70
`define OFS_PIN_MODE 8'hf0
`define OFS_GPIO_OUT 8'hf1
`define OFS_GPIO_IN 8'hf2

// logical device numbers
`define LDN_CHAN_A 8'h00
`define LDN_CHAN_B 8'h01
`define LDN_WATCHDOG 8'h08

// strap defaults
`define DEF_ENABLE 8'h01
`define DEF_NONE 8'h00
`define DEF_A_BASE_HIGH 8'h03
`define DEF_B_BASE_HIGH 8'h02
`define DEF_W_BASE_HIGH 8'h04
`define DEF_LOW_STRAP_BASE_LOW 8'he0
`define DEF_HIGH_STRAP_BASE_LOW 8'hf8
`define DEF_W_BASE_LOW 8'h42
`define DEF_A_IRQ 8'h03
`define DEF_B_IRQ 8'h04
`define DEF_W_IRQ 8'h00

// pin mode bit positions (1 = general purpose)
`define PM_SEND_REQUEST 0
`define PM_TERMINAL_READY 1
`define PM_SET_READY 2
`define PM_RING 3
`define PM_CARRIER 4

// gpio in bit positions
`define GI_SET_READY 0
`define GI_RING 1
`define GI_CARRIER 2

// synchroniser vector: bit positions and reset levels
`define SY_STRAP_A_LOW 0
`define SY_STRAP_A_HIGH 1
`define SY_STRAP_B_LOW 2
`define SY_STRAP_B_HIGH 3
`define SY_STRAP_WDT 4
`define SY_RX 5
`define SY_IR_RX 6
`define SY_SET_READY_N 7
`define SY_RING_N 8
`define SY_CARRIER_N 9
`define SY_WIDTH 10
`define SY_RESET 10'h3bf

`endif

// *** strap_loader_pkg.sv ***
// types shared by the strap loader files
package strap_loader_pkg;

  // configuration byte
  typedef logic [7:0] cfg_byte_t;

  // configured units, used as register array index
  typedef enum logic [1:0] {
    UNIT_A = 2'b00,
    UNIT_B = 2'b01,
    UNIT_WDT = 2'b10
  } cfg_unit_t;

  // strap capture sequence after reset release
  typedef enum logic [1:0] {
    CAP_SYNC1 = 2'b00,
    CAP_SYNC2 = 2'b01,
    CAP_LOAD = 2'b10,
    CAP_DONE = 2'b11
  } capture_state_t;

endpackage

// *** strap_default_decoder.sv ***
// combinational decode of five strap levels into unit default values
`timescale 1ns/1ps
`default_nettype none
`include "strap_loader_consts.svh"

module strap_default_decoder (
  input wire logic a_low_i, // channel a low-base strap
  input wire logic a_high_i, // channel a high-base strap
  input wire logic b_low_i, // channel b low-base strap
  input wire logic b_high_i, // channel b high-base strap
  input wire logic wdt_i, // watchdog strap
  output logic [2:0][7:0] enable_o, // default enable per unit
  output logic [2:0][7:0] base_high_o, // default base high per unit
  output logic [2:0][7:0] base_low_o, // default base low per unit
  output logic [2:0][7:0] irq_o // default irq select per unit
);

  // base low: high strap wins, giving the x_f8 base when both are high
  function automatic strap_loader_pkg::cfg_byte_t base_low_of(input logic lo, input logic hi);
    if (hi) begin
      base_low_of = `DEF_HIGH_STRAP_BASE_LOW;
    end else if (lo) begin
      base_low_of = `DEF_LOW_STRAP_BASE_LOW;
    end else begin
      base_low_of = `DEF_NONE;
    end
  endfunction

  // any high strap of a channel loads enable, base high and irq
  wire a_any = a_low_i | a_high_i;
  wire b_any = b_low_i | b_high_i;

  // channel a defaults
  assign enable_o[strap_loader_pkg::UNIT_A] = a_any ? `DEF_ENABLE : `DEF_NONE;
  assign base_high_o[strap_loader_pkg::UNIT_A] = a_any ? `DEF_A_BASE_HIGH : `DEF_NONE;
  assign base_low_o[strap_loader_pkg::UNIT_A] = base_low_of(a_low_i, a_high_i);
  assign irq_o[strap_loader_pkg::UNIT_A] = a_any ? `DEF_A_IRQ : `DEF_NONE;

  // channel b defaults
  assign enable_o[strap_loader_pkg::UNIT_B] = b_any ? `DEF_ENABLE : `DEF_NONE;
  assign base_high_o[strap_loader_pkg::UNIT_B] = b_any ? `DEF_B_BASE_HIGH : `DEF_NONE;
  assign base_low_o[strap_loader_pkg::UNIT_B] = base_low_of(b_low_i, b_high_i);
  assign irq_o[strap_loader_pkg::UNIT_B] = b_any ? `DEF_B_IRQ : `DEF_NONE;

  // watchdog defaults
  assign enable_o[strap_loader_pkg::UNIT_WDT] = wdt_i ? `DEF_ENABLE : `DEF_NONE;
  assign base_high_o[strap_loader_pkg::UNIT_WDT] = wdt_i ? `DEF_W_BASE_HIGH : `DEF_NONE;
  assign base_low_o[strap_loader_pkg::UNIT_WDT] = wdt_i ? `DEF_W_BASE_LOW : `DEF_NONE;
  assign irq_o[strap_loader_pkg::UNIT_WDT] = `DEF_W_IRQ;

  // unused fourth index does not exist: arrays are three deep

endmodule
`default_nettype wire

// *** strap_loader_props.sv ***
// concurrent checks on the strap loader ports
`timescale 1ns/1ps
`default_nettype none
module strap_loader_props (
  input wire logic sys_clk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic cfg_wr_i, // write strobe
  input wire logic [7:0] cfg_ldn_i, // unit number
  input wire logic [7:0] cfg_index_i, // register index
  input wire logic [7:0] cfg_wdata_i, // write data
  input wire logic [7:0] cfg_rdata_o, // read data
  input wire logic cfg_ready_o, // capture done
  input wire logic a_tx_bit_i, // serial bit
  input wire logic a_ir_tx_bit_i, // infrared bit
  input wire logic watchdog_fire_i, // watchdog fired
  input wire logic chan_a_serial_out_o, // serial out level
  input wire logic chan_a_serial_out_oe_o, // serial out enable
  input wire logic chan_a_infrared_out_o, // infrared out
  input wire logic watchdog_expire_n_o, // watchdog level
  input wire logic watchdog_expire_n_oe_o // watchdog enable
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // a mapped unit and one of its strapped registers
  wire unit_hit = (cfg_ldn_i == 8'h00) || (cfg_ldn_i == 8'h01) || (cfg_ldn_i == 8'h08);
  wire reg_hit = (cfg_index_i == 8'h30) || (cfg_index_i == 8'h60) || (cfg_index_i == 8'h61) || (cfg_index_i == 8'h70);
  // capture takes three quiet edges before ready shows
  sequence s_capture; !cfg_ready_o [*3]; endsequence
  sequence s_ready; cfg_ready_o; endsequence
  sequence s_write; cfg_wr_i && cfg_ready_o && unit_hit && reg_hit; endsequence
  sequence s_hold; $stable(cfg_ldn_i) && $stable(cfg_index_i); endsequence
  property p_capture; $rose(resetn_i) |-> s_capture ##1 s_ready; endproperty
  a_capture: assert property (p_capture) else $error("capture timing wrong");
  property p_ready_hold; cfg_ready_o |=> cfg_ready_o; endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
  // strap balls stay released until the capture is over
  property p_release; $rose(cfg_ready_o) |-> !chan_a_serial_out_oe_o ##1 chan_a_serial_out_oe_o; endproperty
  a_release: assert property (p_release) else $error("strap ball drive order wrong");
  property p_tx_idle; a_tx_bit_i |=> chan_a_serial_out_o; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("serial out not idle high");
  property p_ir_idle; !a_ir_tx_bit_i |=> !chan_a_infrared_out_o; endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("infrared out not idle low");
  property p_wdt_quiet; !watchdog_fire_i |=> !watchdog_expire_n_oe_o; endproperty
  a_wdt_quiet: assert property (p_wdt_quiet) else $error("watchdog pulls without fire");
  property p_wdt_low; watchdog_expire_n_oe_o |-> !watchdog_expire_n_o; endproperty
  a_wdt_low: assert property (p_wdt_low) else $error("watchdog drives high");
  // a written register reads back the written byte
  property p_readback; s_write ##1 s_hold |=> cfg_rdata_o == $past(cfg_wdata_i, 2); endproperty
  a_readback: assert property (p_readback) else $error("write not read back");
  property p_unmapped; !unit_hit |=> cfg_rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped unit reads nonzero");
endmodule
bind strap_default_config_loader strap_loader_props u_props (.sys_clk_i, .resetn_i, .cfg_wr_i, .cfg_ldn_i,
  .cfg_index_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ready_o, .a_tx_bit_i, .a_ir_tx_bit_i, .watchdog_fire_i,
  .chan_a_serial_out_o, .chan_a_serial_out_oe_o, .chan_a_infrared_out_o, .watchdog_expire_n_o,
  .watchdog_expire_n_oe_o);
`default_nettype wire

// *** strap_board_model.sv ***
// board around the strap balls: resistors and far line senders
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
  input wire logic [4:0] strap_i, // 1 leaves pull-up, 0 fits pull-down
  input wire logic [4:0] drv_i, // level driven per ball
  input wire logic [4:0] oe_i, // device drives the ball
  input wire logic busy_i, // far sender mid-character
  input wire logic rx_bit_i, // far serial bit
  input wire logic ir_bit_i, // far infrared bit
  output logic [4:0] ball_o, // resolved ball levels
  output logic serial_in_o, // serial receive line
  output logic infrared_in_o // infrared receive line
);
  // undriven balls sit at their resistor, open drain watchdog only pulls low
  assign ball_o = (oe_i & drv_i) | (~oe_i & strap_i);
  assign serial_in_o = busy_i ? rx_bit_i : 1'b1;
  assign infrared_in_o = busy_i ? ir_bit_i : 1'b0;
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the strap loader
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, cfg_wr_i = 1'b0; // clock, reset, strobe
  logic [7:0] cfg_ldn_i = 8'h00, cfg_index_i = 8'h00, cfg_wdata_i = 8'h00; // config port
  logic a_tx_bit_i = 1'b1, a_ir_tx_bit_i = 1'b0, a_send_request_i = 1'b0, a_terminal_ready_i = 1'b0; // channel a
  logic watchdog_fire_i = 1'b0, chan_a_set_ready_n_i = 1'b1, chan_a_ring_n_i = 1'b1, chan_a_carrier_n_i = 1'b1;
  logic busy = 1'b0, rx_bit = 1'b1, ir_bit = 1'b0; // far senders
  logic [4:0] strap = 5'h1f; // {wdt, b high, b low, a high, a low}
  wire logic [7:0] cfg_rdata_o; // read data
  wire logic cfg_ready_o, a_rx_bit_o, a_ir_rx_bit_o, a_set_ready_o, a_ring_o, a_carrier_o, rx_line, ir_line;
  wire logic chan_a_serial_out_o, chan_a_serial_out_oe_o, chan_a_terminal_ready_n_o, chan_a_terminal_ready_n_oe_o;
  wire logic chan_b_serial_out_o, chan_b_serial_out_oe_o, chan_b_terminal_ready_n_o, chan_b_terminal_ready_n_oe_o;
  wire logic chan_a_send_request_n_o, chan_a_infrared_out_o, watchdog_expire_n_o, watchdog_expire_n_oe_o;
  wire logic [4:0] ball; // resolved strap balls
  int err_count = 0;
  int samples_checked = 0;
  logic [7:0] d; // read byte
  logic [31:0] got; // unit registers {enable, base high, base low, irq}
  logic [4:0] pats [4] = '{5'b11111, 5'b01001, 5'b10110, 5'b00000}; // strap patterns
  logic [7:0] idx [4] = '{8'h30, 8'h60, 8'h61, 8'h70}; // strapped register indexes
  logic [7:0] ldns [3] = '{8'h00, 8'h01, 8'h08}; // unit numbers

  strap_default_config_loader u_dut (.sys_clk_i, .resetn_i, .cfg_wr_i, .cfg_ldn_i, .cfg_index_i, .cfg_wdata_i,
    .cfg_rdata_o, .cfg_ready_o, .a_tx_bit_i, .a_ir_tx_bit_i, .a_send_request_i, .a_terminal_ready_i,
    .b_tx_bit_i(a_tx_bit_i), .b_terminal_ready_i(a_terminal_ready_i), .watchdog_fire_i, .a_rx_bit_o,
    .a_ir_rx_bit_o, .a_set_ready_o, .a_ring_o, .a_carrier_o, .chan_a_serial_out_i(ball[1]),
    .chan_a_serial_out_o, .chan_a_serial_out_oe_o,
    .chan_a_terminal_ready_n_i(ball[0]), .chan_a_terminal_ready_n_o, .chan_a_terminal_ready_n_oe_o,
    .chan_a_send_request_n_o, .chan_a_infrared_out_o, .chan_a_serial_in_i(rx_line), .chan_a_infrared_in_i(ir_line),
    .chan_a_set_ready_n_i, .chan_a_ring_n_i, .chan_a_carrier_n_i, .chan_b_serial_out_i(ball[3]),
    .chan_b_serial_out_o, .chan_b_serial_out_oe_o, .chan_b_terminal_ready_n_i(ball[2]), .chan_b_terminal_ready_n_o,
    .chan_b_terminal_ready_n_oe_o, .watchdog_expire_n_i(ball[4]), .watchdog_expire_n_o, .watchdog_expire_n_oe_o);

  strap_board_model u_board (.strap_i(strap), .drv_i({watchdog_expire_n_o, chan_b_serial_out_o,
    chan_b_terminal_ready_n_o, chan_a_serial_out_o, chan_a_terminal_ready_n_o}), .oe_i({watchdog_expire_n_oe_o,
    chan_b_serial_out_oe_o, chan_b_terminal_ready_n_oe_o, chan_a_serial_out_oe_o, chan_a_terminal_ready_n_oe_o}),
    .busy_i(busy), .rx_bit_i(rx_bit), .ir_bit_i(ir_bit), .ball_o(ball), .serial_in_o(rx_line), .infrared_in_o(ir_line));

  // 5 ns clock
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic report_and_stop();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // read data lags the presented index by one edge
  task automatic rd_reg(input logic [7:0] l, input logic [7:0] i, output logic [7:0] v);
    @(posedge sys_clk_i);
    cfg_ldn_i <= l;
    cfg_index_i <= i;
    tick(2);
    v = cfg_rdata_o;
  endtask

  task automatic wr_reg(input logic [7:0] l, input logic [7:0] i, input logic [7:0] v);
    @(posedge sys_clk_i);
    {cfg_ldn_i, cfg_index_i, cfg_wdata_i, cfg_wr_i} <= {l, i, v, 1'b1};
    @(posedge sys_clk_i);
    cfg_wr_i <= 1'b0;
  endtask

  task automatic rd_unit(input logic [7:0] l, output logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      rd_reg(l, idx[i], v[31 - 8 * i -: 8]);
    end
  endtask

  // expected defaults of one unit from its two straps
  function automatic logic [31:0] dflt(input logic lo, input logic hi, input logic [7:0] bh, input logic [7:0] blh,
      input logic [7:0] bll, input logic [7:0] irq);
    if (!(lo || hi)) return 32'h0;
    return {8'h01, bh, hi ? blh : bll, irq};
  endfunction

  // line drives, modem pins and general purpose mode, first with every unit enabled, then with channel a disabled
  task automatic pin_tests();
    @(posedge sys_clk_i);
    {a_tx_bit_i, a_ir_tx_bit_i, a_send_request_i, a_terminal_ready_i, watchdog_fire_i} <= 5'b01111;
    {chan_a_set_ready_n_i, chan_a_ring_n_i, busy, rx_bit, ir_bit} <= 5'b00101;
    tick(1);
    chk({chan_a_serial_out_o, chan_a_infrared_out_o, chan_a_send_request_n_o, chan_a_terminal_ready_n_o}, 4'b0100);
    chk({watchdog_expire_n_oe_o, watchdog_expire_n_o}, 2'b10);
    chk({chan_a_serial_out_oe_o, chan_a_terminal_ready_n_oe_o}, 2'b11);
    chk({chan_b_serial_out_oe_o, chan_b_terminal_ready_n_oe_o}, 2'b11);
    chk({chan_b_serial_out_o, chan_b_terminal_ready_n_o}, 2'b00);
    tick(2);
    chk({a_set_ready_o, a_ring_o, a_carrier_o, a_rx_bit_o, a_ir_rx_bit_o, ball[4]}, 6'b110010);
    @(posedge sys_clk_i);
    {a_tx_bit_i, a_ir_tx_bit_i, watchdog_fire_i, busy} <= 4'b1000;
    wr_reg(8'h00, 8'hf0, 8'h1f);
    wr_reg(8'h00, 8'hf1, 8'h01);
    tick(2);
    chk({chan_a_send_request_n_o, chan_a_terminal_ready_n_o, a_set_ready_o, a_ring_o, a_carrier_o}, 5'b10000);
    rd_reg(8'h00, 8'hf2, d);
    chk(d, 8'h04);
    wr_reg(8'h00, 8'h30, 8'h00);
    @(posedge sys_clk_i);
    {a_tx_bit_i, a_ir_tx_bit_i} <= 2'b01;
    tick(2);
    chk({chan_a_serial_out_o, chan_a_infrared_out_o, a_rx_bit_o, a_ir_rx_bit_o}, 4'b1010);
    for (int u = 0; u < 3; u++) begin
      for (int i = 0; i < 4; i++) begin
        wr_reg(ldns[u], idx[i], idx[i] ^ ldns[u] ^ 8'ha5);
      end
      rd_unit(ldns[u], got);
      chk(got, {idx[0], idx[1], idx[2], idx[3]} ^ {4{ldns[u] ^ 8'ha5}});
    end
    wr_reg(8'h05, 8'h30, 8'h77);
    rd_reg(8'h05, 8'h30, d);
    chk(d, 8'h00);
  endtask

  // hang guard
  initial begin
    #100us;
    err_count++;
    report_and_stop();
  end

  initial begin
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i);
      resetn_i <= 1'b0;
      strap <= pats[k];
      tick(20);
      chk({chan_a_serial_out_o, chan_a_serial_out_oe_o, chan_a_infrared_out_o, watchdog_expire_n_oe_o}, 4'b1000);
      @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      if (k == 1) wr_reg(8'h00, 8'h30, 8'h00);
      for (int n = 0; n < 20 && cfg_ready_o !== 1'b1; n++) begin
        tick(1);
      end
      chk(cfg_ready_o, 1'b1);
      rd_unit(8'h00, got);
      chk(got, dflt(pats[k][0], pats[k][1], 8'h03, 8'hf8, 8'he0, 8'h03));
      if (k == 0) chk(got[23:8], 16'h03f8);
      rd_unit(8'h01, got);
      chk(got, dflt(pats[k][2], pats[k][3], 8'h02, 8'hf8, 8'he0, 8'h04));
      if (k == 0) chk(got[23:8], 16'h02f8);
      rd_unit(8'h08, got);
      chk(got, dflt(pats[k][4], pats[k][4], 8'h04, 8'h42, 8'h42, 8'h00));
      if (k == 0) pin_tests();
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
